/* File: tb/pdac_filter_model.sv */
// Pin load: an integrator standing in for the smoothing filter.
// Assumes the pin is sampled on the system clock edge.
`timescale 1ns/10ps
`default_nettype none
module pdac_filter_model (
  // Clock and control
  input  wire logic        clk_sys,
  input  wire logic        clear,
  // Pin under load
  input  wire logic        pin,
  // High cycles since clear; mean level is this over the window
  output logic      [15:0] high_count
);
  // Unknown pin level counts as low, so it can never pass
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      high_count <= 16'h0000;
    end else if (pin === 1'b1) begin
      high_count <= high_count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* File: tb/pdac_top_properties.sv */
// Checker for the PWM block's processor port and pins.
// Assumes it is bound to pdac_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "pdac_consts.svh"
module pdac_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Processor port
  input wire logic [23:0] cpu_addr,
  input wire logic        cpu_wr,
  input wire logic        cpu_rd,
  input wire logic [7:0]  cpu_wdata,
  input wire logic [7:0]  cpu_rdata,
  // Pins
  input wire logic        chan_a_output_pin,
  input wire logic        chan_b_output_pin
);
  logic       bank_reg;
  logic [3:0] ctrl_reg;
  logic       rd_a0;
  logic       rd_a1;
  logic       rd_a7;
  logic       rd_bad;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Bank bit: any write at the low counter address loads it from data bit 0
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bank_reg <= 1'b0;
    end else if (cpu_wr && cpu_addr == `PDAC_ADDR_CNT_LO) begin
      bank_reg <= cpu_wdata[0];
    end
  end
  // Low control nibble; only reachable with the bank bit set
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= 4'h0;
    end else if (cpu_wr && bank_reg && cpu_addr == `PDAC_ADDR_CTRL_DATA_HI) begin
      ctrl_reg <= cpu_wdata[3:0];
    end
  end
  // Read decodes
  assign rd_a0  = cpu_rd && cpu_addr == `PDAC_ADDR_CTRL_DATA_HI;
  assign rd_a1  = cpu_rd && cpu_addr == `PDAC_ADDR_DATA_LO;
  assign rd_a7  = cpu_rd && cpu_addr == `PDAC_ADDR_CNT_LO;
  assign rd_bad = cpu_rd && !rd_a0 && !rd_a1 && !rd_a7 && cpu_addr != `PDAC_ADDR_CNT_HI;

  property p_rst_quiet;
    disable iff (1'b0) rst |=> cpu_rdata == 8'h00 && !chan_a_output_pin && !chan_b_output_pin;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet in reset");
  property p_rd_hold;
    !cpu_rd |=> $stable(cpu_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_bad;
    rd_bad |-> ##1 cpu_rdata == `PDAC_UNMAPPED_READ;
  endproperty
  a_bad: assert property (p_bad) else $error("unmapped read not FF");
  property p_a1_bank1;
    rd_a1 && bank_reg |=> cpu_rdata == `PDAC_UNMAPPED_READ;
  endproperty
  a_a1_bank1: assert property (p_a1_bank1) else $error("data low seen in bank 1");
  property p_data_lo;
    rd_a1 && !bank_reg |=> cpu_rdata[0];
  endproperty
  a_data_lo: assert property (p_data_lo) else $error("data low bit 0 not 1");
  property p_cnt_lo;
    rd_a7 && bank_reg |=> cpu_rdata[1:0] == 2'b11;
  endproperty
  a_cnt_lo: assert property (p_cnt_lo) else $error("counter low flags wrong");
  property p_ctrl_rd;
    rd_a0 && bank_reg |=> cpu_rdata[5:0] == {2'b11, $past(ctrl_reg)};
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read wrong");
  property p_oe_a;
    !ctrl_reg[2] [*2] |-> !chan_a_output_pin;
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin a driven while off");
  property p_oe_b;
    !ctrl_reg[3] [*2] |-> !chan_b_output_pin;
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("pin b driven while off");
endmodule
`default_nettype wire

/* File: tb/tb_pwm_14bit_da_channel.sv */
// Testbench for the PWM block: registers, duty, polarity, range, rate.
// Assumes the design, the filter model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "pdac_consts.svh"
module tb_pwm_14bit_da_channel;
  localparam logic [23:0] A0 = `PDAC_ADDR_CTRL_DATA_HI;
  localparam logic [23:0] A1 = `PDAC_ADDR_DATA_LO;
  localparam logic [23:0] A6 = `PDAC_ADDR_CNT_HI;
  localparam logic [23:0] A7 = `PDAC_ADDR_CNT_LO;
  logic        clk_sys   = 1'b0;
  logic        rst       = 1'b1;
  logic [23:0] cpu_addr  = 24'h000000;
  logic        cpu_wr    = 1'b0;
  logic        cpu_rd    = 1'b0;
  logic [7:0]  cpu_wdata = 8'h00;
  logic [7:0]  cpu_rdata;
  logic        pin_a;
  logic        pin_b;
  logic        clear     = 1'b1;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  int          failures  = 0;
  int          n_tests   = 0;

  pdac_top i_dut (.clk_sys(clk_sys), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .chan_a_output_pin(pin_a), .chan_b_output_pin(pin_b));
  pdac_filter_model i_load_a (.clk_sys(clk_sys), .clear(clear), .pin(pin_a), .high_count(cnt_a));
  pdac_filter_model i_load_b (.clk_sys(clk_sys), .clear(clear), .pin(pin_b), .high_count(cnt_b));

  // 100 MHz system clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_wr    <= 1'b1;
    @(posedge clk_sys);
    cpu_wr <= 1'b0;
  endtask
  task automatic rd(input logic [23:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_rd   <= 1'b1;
    @(posedge clk_sys);
    cpu_rd <= 1'b0;
    #1;
    d = cpu_rdata;
  endtask
  task automatic rdc(input logic [23:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    check($sformatf("read %h", a), {8'h00, v}, {8'h00, e});
  endtask
  // Loads both data words, the control byte, then returns to bank 0
  task automatic setup(input logic [15:0] wa, input logic [15:0] wb, input logic [7:0] ctl);
    wr(A0, wa[15:8]);
    wr(A1, wa[7:0]);
    wr(A6, wb[15:8]);
    wr(A7, wb[7:0] | 8'h01);
    wr(A0, ctl);
    rdc(A0, ctl | 8'h30);
    rdc(A1, 8'hFF);
    wr(A6, 8'h00);
    wr(A7, 8'h00);
    rdc(A0, wa[15:8]);
    rdc(A1, wa[7:0] | 8'h01);
  endtask
  // Waits out the shadow load, then integrates n cycles of both pins
  task automatic measure(input logic [15:0] ea, input logic [15:0] eb, input int n);
    repeat (300) @(posedge clk_sys);
    clear <= 1'b1;
    @(posedge clk_sys);
    clear <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
    check("pin a", cnt_a, ea);
    check("pin b", cnt_b, eb);
  endtask
  task automatic rd_cnt(output logic [13:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(A6, h);
    rd(A7, l);
    v = {h, l[7:2]};
  endtask

  task automatic t_reset();
    rdc(A0, 8'h00);
    rdc(A1, 8'h03);
    rdc(A6, 8'h00);
    rdc(24'hFFFFA2, `PDAC_UNMAPPED_READ);
    measure(16'h0000, 16'h0000, 64);
    $display("done reset values");
  endtask
  // Full conversion period: high time equals the 14-bit data value
  task automatic t_duty();
    setup(16'h0207, 16'h1002, 8'h0C);
    measure(16'h0207 >> 2, 16'h1002 >> 2, 16384);
    $display("done duty 256");
  endtask
  task automatic t_inv();
    setup(16'h0804, 16'h0401, 8'h0E);
    measure(16'h4000 - (16'h0804 >> 2), 16'h4000 - (16'h0401 >> 2), 16384);
    $display("done duty 64 inverted");
  endtask
  // Below-range words hold raw low, so the inverted pin stays high
  task automatic t_range();
    setup(16'h00FF, 16'h03FC, 8'h0E);
    measure(16'd600, 16'd600, 600);
    $display("done out of range");
  endtask
  task automatic t_oe();
    setup(16'h0207, 16'h1002, 8'h02);
    measure(16'h0000, 16'h0000, 600);
    $display("done output off");
  endtask
  // Data written mid-cycle waits for the base-cycle boundary; both looks at position ~101
  task automatic t_defer();
    setup(16'h8003, 16'h8003, 8'h04);
    repeat (300) @(posedge clk_sys);
    wr(A0, 8'h01);
    wr(A1, 8'h03);
    repeat (50) @(posedge clk_sys);
    #1;
    check("pin a old width", {15'h0000, pin_a}, 16'h0001);
    repeat (256) @(posedge clk_sys);
    #1;
    check("pin a new width", {15'h0000, pin_a}, 16'h0000);
    $display("done deferred data");
  endtask
  // Two counter reads 64 clocks apart
  task automatic t_rate(input logic resolution_select);
    logic [13:0] v1;
    logic [13:0] v2;
    wr(A6, 8'h00);
    wr(A7, 8'h01);
    wr(A0, {7'h00, resolution_select});
    wr(A6, 8'h12);
    wr(A7, 8'h01);
    rd_cnt(v1);
    check("count hi", {8'h00, v1[13:6]}, 16'h0012);
    repeat (60) @(posedge clk_sys);
    rd_cnt(v2);
    check("count step", {2'b00, v2 - v1}, resolution_select ? 16'h0020 : 16'h0040);
    wr(A7, 8'h00);
    $display("done count rate");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst   <= 1'b0;
    clear <= 1'b0;
    t_reset();
    t_duty();
    t_inv();
    t_range();
    t_oe();
    t_defer();
    t_rate(1'b0);
    t_rate(1'b1);
    test_done();
  end
  // Watchdog: tests need about 36k cycles
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    test_done();
  end
endmodule
bind pdac_top pdac_checker i_chk (.clk_sys(clk_sys), .rst(rst), .cpu_addr(cpu_addr),
  .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
  .chan_a_output_pin(chan_a_output_pin), .chan_b_output_pin(chan_b_output_pin));
`default_nettype wire

/* File: verilog/pdac_channel.sv */
// One PWM channel: shadows its data word and compares it with the counter.
// Assumes the counter and tick come from the top module on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "pdac_consts.svh"

module pdac_channel (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Time base
  input  wire logic        tick,
  input  wire logic [13:0] cnt,
  // Data word as software last wrote it
  input  wire logic [15:0] data_word,
  // Raw waveform, before polarity and enable
  output logic             wave
);

  logic [15:0] shadow_reg;
  logic        carrier_cycle_select;
  logic        in_range;
  logic        cycle_end;
  logic        extra_256;
  logic        extra_64;
  logic [8:0]  width_256;
  logic [6:0]  width_64;

  // Bit reversal spreads the extra pulses evenly over the conversion period
  function automatic logic [5:0] rev6(input logic [5:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 6; i++) begin
      r[i] = v[5 - i];
    end
    return r;
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  assign carrier_cycle_select = shadow_reg[`PDAC_DATA_CARRIER_BIT];

  // Last resolution period of a base cycle, per carrier setting
  assign cycle_end = carrier_cycle_select ? (cnt[7:0] == 8'hFF) : (cnt[5:0] == 6'h3F);

  // New data only at a base-cycle boundary, so no pulse gets cut short
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shadow_reg <= `PDAC_DATA_RESET;
    end else if (tick && cycle_end) begin
      shadow_reg <= data_word; // RL13
    end
  end

  // Outside the permitted range the output stays constant
  assign in_range = carrier_cycle_select ?
    (shadow_reg >= `PDAC_RANGE256_LO && shadow_reg <= `PDAC_RANGE256_HI) : // RL6
    (shadow_reg >= `PDAC_RANGE64_LO && shadow_reg <= `PDAC_RANGE64_HI);    // RL5

  // 256-period carrier: 8 bits of width, 6 bits place extra pulses
  assign extra_256 = rev6(cnt[13:8]) < shadow_reg[7:2]; // RL10
  assign width_256 = {1'b0, shadow_reg[15:8]} + {8'h00, extra_256}; // RL11

  // 64-period carrier: 6 bits of width, 8 bits place extra pulses
  assign extra_64 = rev8(cnt[13:6]) < shadow_reg[9:2];
  assign width_64 = {1'b0, shadow_reg[15:10]} + {6'h00, extra_64}; // RL11

  // Base pulse high from position zero up to its width
  always_comb begin
    if (!in_range) begin
      wave = 1'b0; // RL9
    end else if (carrier_cycle_select) begin
      wave = {1'b0, cnt[7:0]} < width_256; // RL6
    end else begin
      wave = {1'b0, cnt[5:0]} < width_64; // RL5
    end
  end

endmodule
`default_nettype wire

/* File: verilog/pdac_consts.svh */
// Constants of the 14-bit pulse-division PWM block: addresses, fields, resets.
// Assumes an 8-bit processor data path with 24-bit byte addresses.
`ifndef PDAC_CONSTS_SVH
`define PDAC_CONSTS_SVH

// Byte addresses of the shared register windows
`define PDAC_ADDR_W            24
`define PDAC_ADDR_CTRL_DATA_HI 24'hFFFFA0
`define PDAC_ADDR_DATA_LO      24'hFFFFA1
`define PDAC_ADDR_CNT_HI       24'hFFFFA6
`define PDAC_ADDR_CNT_LO       24'hFFFFA7

// Control register fields
`define PDAC_CTRL_TEST_BIT     7
`define PDAC_CTRL_ENABLE_BIT   6
`define PDAC_CTRL_OE_B_BIT     3
`define PDAC_CTRL_OE_A_BIT     2
`define PDAC_CTRL_INVERT_BIT   1
`define PDAC_CTRL_RES_BIT      0
`define PDAC_CTRL_RSVD_MASK    8'h30
`define PDAC_CTRL_RESET        8'h30

// Data word fields
`define PDAC_DATA_CARRIER_BIT  1
`define PDAC_DATA_RESET        16'h0003

// Counter word fields
`define PDAC_CNT_RESET         14'h0000
`define PDAC_CNT_REGS_BIT      0

// Permitted data ranges per carrier setting
`define PDAC_RANGE64_LO        16'h0401
`define PDAC_RANGE64_HI        16'hFFFD
`define PDAC_RANGE256_LO       16'h0103
`define PDAC_RANGE256_HI       16'hFFFF

// Read value of an unmapped byte
`define PDAC_UNMAPPED_READ     8'hFF

`endif

/* File: verilog/pdac_pkg.sv */
// Types shared by the 14-bit pulse-division PWM block.
// Assumes the constants header is compiled alongside.
package pdac_pkg;

  // Which register byte a processor access lands on
  typedef enum logic [2:0] {
    TGT_NONE    = 3'b000,
    TGT_CTRL    = 3'b001,
    TGT_DATA_HI = 3'b010,
    TGT_DATA_LO = 3'b011,
    TGT_CNT_HI  = 3'b110,
    TGT_CNT_LO  = 3'b111
  } pdac_target_type;

endpackage

/* File: verilog/pdac_top.sv */
// Summary of operation
// RL1: Invert bit flips the channel waveform.
// RL2: Resolution bit: count every one or two clocks.
// RL3: High data byte holds upper eight bits.
// RL4: Low byte: six data bits plus carrier select.
// RL5: Carrier clear: 64-period base, range checked.
// RL6: Carrier set: 256-period base, range checked.
// RL7: Readable, writable 14-bit counter in bits 15..2.
// RL8: Counter bit zero selects register bank.
// RL9: Out-of-range data holds output constant.
// RL10: Upper bits width, lower bits extra pulses.
// RL11: Extra pulse adds one resolution period.
// RL12: Enable bit gates each channel onto pin.
// RL13: New data applies from next base cycle.
//
// Top of the 14-bit pulse-division PWM block with its processor registers.
// Assumes a synchronous 8-bit processor port and an external RC filter per pin.
`timescale 1ns/10ps
`default_nettype none
`include "pdac_consts.svh"

module pdac_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Processor port
  input  wire logic [23:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [7:0]  cpu_wdata,
  output wire logic [7:0]  cpu_rdata,
  // PWM pins
  output wire logic        chan_a_output_pin,
  output wire logic        chan_b_output_pin
);

  // Number of channels sharing the counter
  localparam int NCHAN = 2;

  // Control register and its fields
  logic [7:0]  pwm_control_reg;
  logic        output_invert_select;
  logic        resolution_select;
  logic [1:0]  chan_output_enable;

  // Data words, channel 0 is A, channel 1 is B
  logic [15:1] duty_data_reg [0:NCHAN-1];
  logic [15:0] duty_data_word [0:NCHAN-1];

  // Counter and bank select
  logic [13:0] pwm_counter_reg;
  logic        bank_sel_reg;
  logic        div_reg;
  logic        tick;

  // Byte staging register for 16-bit transfers
  logic [7:0]  temp_reg;

  // Access decode
  pdac_pkg::pdac_target_type target;
  logic        target_chan;
  logic        wr_ctrl;
  logic        wr_data_lo;
  logic        wr_cnt_lo;

  // Read path and pins
  logic [7:0]       cpu_rdata_reg;
  logic [7:0]       rdata_next;
  logic [NCHAN-1:0] wave;
  logic [NCHAN-1:0] pin_reg;

  // Address and bank to register byte; used by both read and write paths
  function automatic pdac_pkg::pdac_target_type decode(
    input logic [23:0] addr,
    input logic        bank
  );
    pdac_pkg::pdac_target_type t;
    t = pdac_pkg::TGT_NONE;
    unique case (addr)
      `PDAC_ADDR_CTRL_DATA_HI: begin
        t = bank ? pdac_pkg::TGT_CTRL : pdac_pkg::TGT_DATA_HI; // RL8
      end
      `PDAC_ADDR_DATA_LO: begin
        t = bank ? pdac_pkg::TGT_NONE : pdac_pkg::TGT_DATA_LO; // RL8
      end
      `PDAC_ADDR_CNT_HI: begin
        t = bank ? pdac_pkg::TGT_CNT_HI : pdac_pkg::TGT_DATA_HI; // RL8
      end
      `PDAC_ADDR_CNT_LO: begin
        t = bank ? pdac_pkg::TGT_CNT_LO : pdac_pkg::TGT_DATA_LO; // RL8
      end
      default: begin
        t = pdac_pkg::TGT_NONE;
      end
    endcase
    return t;
  endfunction

  // Channel B data shares the counter's addresses while the bank is clear
  function automatic logic decode_chan(input logic [23:0] addr);
    return (addr == `PDAC_ADDR_CNT_HI) || (addr == `PDAC_ADDR_CNT_LO);
  endfunction

  assign target      = decode(cpu_addr, bank_sel_reg);
  assign target_chan = decode_chan(cpu_addr);
  assign wr_ctrl     = cpu_wr && (target == pdac_pkg::TGT_CTRL);
  assign wr_data_lo  = cpu_wr && (target == pdac_pkg::TGT_DATA_LO);
  assign wr_cnt_lo   = cpu_wr && (target == pdac_pkg::TGT_CNT_LO);

  // Control fields
  assign output_invert_select  = pwm_control_reg[`PDAC_CTRL_INVERT_BIT];
  assign resolution_select     = pwm_control_reg[`PDAC_CTRL_RES_BIT];
  assign chan_output_enable[0] = pwm_control_reg[`PDAC_CTRL_OE_A_BIT];
  assign chan_output_enable[1] = pwm_control_reg[`PDAC_CTRL_OE_B_BIT];

  // Control register; reserved bits stay at one
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwm_control_reg <= `PDAC_CTRL_RESET;
    end else if (wr_ctrl) begin
      pwm_control_reg <= cpu_wdata | `PDAC_CTRL_RSVD_MASK;
    end
  end

  // Staging byte: high-byte writes park here, high-byte reads park the low half
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      temp_reg <= 8'h00;
    end else if (cpu_wr && (target == pdac_pkg::TGT_DATA_HI ||
                            target == pdac_pkg::TGT_CNT_HI)) begin
      temp_reg <= cpu_wdata;
    end else if (cpu_rd && target == pdac_pkg::TGT_DATA_HI) begin
      temp_reg <= {duty_data_reg[target_chan][7:1], 1'b1};
    end else if (cpu_rd && target == pdac_pkg::TGT_CNT_HI) begin
      temp_reg <= {pwm_counter_reg[5:0], 1'b1, bank_sel_reg};
    end
  end

  // Data words commit whole on the low-byte write, never half updated
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < NCHAN; i++) begin
        duty_data_reg[i] <= 15'(`PDAC_DATA_RESET >> 1);
      end
    end else if (wr_data_lo) begin
      duty_data_reg[target_chan][15:8] <= temp_reg;        // RL3
      duty_data_reg[target_chan][7:1]  <= cpu_wdata[7:1];  // RL4
    end
  end

  // Least significant data bit has no storage and reads as one
  generate
    for (genvar g = 0; g < NCHAN; g++) begin : g_word
      assign duty_data_word[g] = {duty_data_reg[g], 1'b1};
    end
  endgenerate

  // Resolution divider: period of one or two system clocks
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_reg <= 1'b0;
    end else begin
      div_reg <= ~div_reg;
    end
  end

  assign tick = ~resolution_select | div_reg; // RL2

  // Counter; a processor write wins over the count in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwm_counter_reg <= `PDAC_CNT_RESET;
    end else if (wr_cnt_lo) begin
      pwm_counter_reg <= {temp_reg, cpu_wdata[7:2]}; // RL7
    end else if (tick) begin
      pwm_counter_reg <= pwm_counter_reg + 14'h0001; // RL7
    end
  end

  // Bank select lives in the counter's low byte
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bank_sel_reg <= 1'b0;
    end else if (cpu_wr && (target == pdac_pkg::TGT_CNT_LO ||
                            (target == pdac_pkg::TGT_DATA_LO && target_chan))) begin
      bank_sel_reg <= cpu_wdata[`PDAC_CNT_REGS_BIT]; // RL8
    end
  end

  // Read mux; bit one of the counter word is reserved and reads one
  always_comb begin
    rdata_next = `PDAC_UNMAPPED_READ;
    unique case (target)
      pdac_pkg::TGT_CTRL: begin
        rdata_next = pwm_control_reg;
      end
      pdac_pkg::TGT_DATA_HI: begin
        rdata_next = duty_data_reg[target_chan][15:8]; // RL3
      end
      pdac_pkg::TGT_DATA_LO: begin
        rdata_next = temp_reg; // RL4
      end
      pdac_pkg::TGT_CNT_HI: begin
        rdata_next = pwm_counter_reg[13:6]; // RL7
      end
      pdac_pkg::TGT_CNT_LO: begin
        rdata_next = temp_reg; // RL7
      end
      pdac_pkg::TGT_NONE: begin
        rdata_next = `PDAC_UNMAPPED_READ;
      end
    endcase
  end

  // Read data registered, valid the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cpu_rdata_reg <= 8'h00;
    end else if (cpu_rd) begin
      cpu_rdata_reg <= rdata_next;
    end
  end

  assign cpu_rdata = cpu_rdata_reg;

  // One waveform engine per channel on the shared time base
  generate
    for (genvar g = 0; g < NCHAN; g++) begin : g_chan
      pdac_channel u_channel (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .tick      (tick),
        .cnt       (pwm_counter_reg),
        .data_word (duty_data_word[g]),
        .wave      (wave[g])
      );
    end
  endgenerate

  // Pin flops: polarity then enable, a disabled pin sits low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_reg <= '0;
    end else begin
      for (int i = 0; i < NCHAN; i++) begin
        pin_reg[i] <= chan_output_enable[i] & (wave[i] ^ output_invert_select); // RL1 RL12
      end
    end
  end

  assign chan_a_output_pin = pin_reg[0];
  assign chan_b_output_pin = pin_reg[1];

endmodule
`default_nettype wire
